/* core/fscs_pkg.sv */
`default_nettype none
package fscs_pkg;
	// Register indices on the configuration port
	localparam logic [8:0] ADDR_SEQ_CTRL   = 9'h0c0;
	localparam logic [8:0] ADDR_WIN_SEL    = 9'h0c3;
	localparam logic [8:0] ADDR_DARK_ROWS  = 9'h0c5;
	localparam logic [8:0] ADDR_FILL_ROWS  = 9'h0c6;
	localparam logic [8:0] ADDR_GAIN_TIME  = 9'h0c7;
	localparam logic [8:0] ADDR_EXPOSURE   = 9'h0cb;
	localparam logic [8:0] ADDR_GAIN       = 9'h0cc;
	localparam logic [8:0] ADDR_FREEZE     = 9'h0ce;
	localparam logic [8:0] ADDR_ROW_ADDR   = 9'h0e6;
	localparam logic [8:0] ADDR_LAST_ROW   = 9'h0e7;
	localparam logic [8:0] ADDR_DECIMATION = 9'h0e8;
	// Field positions
	localparam int SEQ_BLANK_WIN_BIT   = 9;
	localparam int GAIN_ALIGN_BIT      = 13;
	localparam int FRZ_HOLD_LINE_LENGTH = 0;
	localparam int FRZ_DARK_ROWS       = 1;
	localparam int FRZ_FILL_ROWS       = 2;
	localparam int FRZ_EXPOSURE        = 3;
	localparam int FRZ_GAIN            = 4;
	localparam int FRZ_WINDOW          = 5;
	localparam int WIN_MASK_W          = 8;
	localparam int DEC_W               = 5;
	localparam int LAST_ROW_W          = 13;
	// Reset values
	localparam logic [15:0] RST_REG    = 16'h0000;
	localparam logic [15:0] RST_FREEZE = 16'h003f;
	// Blank sequencer states, Gray coded
	typedef enum logic [1:0] {
		FSCS_RUN   = 2'b00,
		FSCS_BLANK = 2'b01
	} fscs_state_e;
endpackage : fscs_pkg
`default_nettype wire

/* core/fscs_blank_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface fscs_blank_if;
	logic frame_start;
	logic blank_req;
	logic blank;
	modport bank (output frame_start, output blank_req, input blank);
	modport gen (input frame_start, input blank_req, output blank);
endinterface : fscs_blank_if
`default_nettype wire

/* core/fscs_blank_gen.sv */
`timescale 1ns/100ps
`default_nettype none
module fscs_blank_gen (
	input  wire logic    clock,
	input  wire logic    rst_n,
	fscs_blank_if.gen    bif
);
	fscs_pkg::fscs_state_e state_q;
	fscs_pkg::fscs_state_e state_d;

	// Decision taken only at a frame start, so a running frame is never cut
	always_comb begin
		state_d = state_q;
		case (state_q)
			fscs_pkg::FSCS_RUN: begin
				if (bif.frame_start && bif.blank_req) begin
					state_d = fscs_pkg::FSCS_BLANK;
				end
			end
			fscs_pkg::FSCS_BLANK: begin
				// One frame only; a fresh request re-arms for the next
				if (bif.frame_start && !bif.blank_req) begin
					state_d = fscs_pkg::FSCS_RUN;
				end
			end
			default: begin
				state_d = fscs_pkg::FSCS_RUN;
			end
		endcase
	end

	// State register
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= fscs_pkg::FSCS_RUN;
		end else begin
			state_q <= state_d;
		end
	end

	assign bif.blank = (state_q == fscs_pkg::FSCS_BLANK);
endmodule : fscs_blank_gen
`default_nettype wire

/* core/fscs_bank.sv */
// Notes on behaviour
// - Frame parameter writes wait in staging and apply only at frame start; sequencer control drives seq_ctrl at once.
// - A change needing settling blanks one frame and sends training patterns.
// - Decimation field change applies at frame start and blanks one frame.
// - Dark-row or filler-row count change blanks one frame.
// - Window switch blanks one frame only when the blank-on-switch bit is set.
// - Only selecting a different window counts as a switch.
// - Exposure changes apply without a blank frame.
// - Gain applies at frame start; align bit adds one frame delay.
// - Cleared freeze bit keeps that group's active values unchanged, except gain while the align bit is set.
// - Set freeze bit loads all staged group values at next frame start.
// - Line length, dark rows and filler rows each have a freeze bit.
// - Exposure freeze bit gates tick scale, frame length and exposure.
// - Gain freeze bit gates column amp select and front-end level.
// - Window freeze bit gates mask, decimation and row address fields.
`timescale 1ns/100ps
`default_nettype none
module fscs_bank (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        cfg_wr,
	input  wire logic        cfg_rd,
	input  wire logic [8:0]  cfg_addr,
	input  wire logic [15:0] cfg_wdata,
	output logic      [15:0] cfg_rdata,
	input  wire logic        frame_start,
	input  wire logic [15:0] line_length_in,
	input  wire logic [15:0] frame_length_cfg_in,
	input  wire logic [15:0] tick_scale_in,
	output logic      [15:0] seq_ctrl,
	output logic      [15:0] line_length,
	output logic      [15:0] frame_length_cfg,
	output logic      [15:0] tick_scale,
	output logic      [15:0] exposure,
	output logic      [15:0] gain,
	output logic      [15:0] dark_rows,
	output logic      [15:0] filler_rows,
	output logic      [7:0]  window_enable_mask,
	output logic      [4:0]  decimation,
	output logic      [15:0] row_address,
	output logic      [12:0] last_row,
	output logic             blank_frame,
	output logic             training_pattern
);
	////////////////////////////////////////////////////////////////////////
	// Staging registers, written by the host at any time
	logic [15:0] seq_q;
	logic [15:0] win_q;
	logic [15:0] dark_q;
	logic [15:0] fill_q;
	logic [15:0] gtime_q;
	logic [15:0] exp_q;
	logic [15:0] gain_q;
	logic [15:0] frz_q;
	logic [15:0] row_q;
	logic [15:0] last_q;
	logic [15:0] dec_q;
	logic [15:0] rdata_q;

	// Active set seen by the readout sequencer
	logic [15:0] act_line_q;
	logic [15:0] act_flen_q;
	logic [15:0] act_tick_q;
	logic [15:0] act_exp_q;
	logic [15:0] act_gain_q;
	logic [15:0] gain_mid_q;
	logic [15:0] act_dark_q;
	logic [15:0] act_fill_q;
	logic [7:0]  act_win_q;
	logic [4:0]  act_dec_q;
	logic [15:0] act_row_q;
	logic [12:0] act_last_q;
	logic        blank_q;

	logic        sync_line;
	logic        sync_dark;
	logic        sync_fill;
	logic        sync_exp;
	logic        sync_gain;
	logic        sync_win;
	logic        gain_align;
	logic        dec_chg;
	logic        rows_chg;
	logic        win_chg;

	fscs_blank_if bif ();

	// freeze picks source
	// Pick staged value when the group follows, else keep active value
	function automatic logic [15:0] fscs_pick(input logic s, input logic [15:0] p,
		input logic [15:0] a);
		fscs_pick = s ? p : a;
	endfunction : fscs_pick

	////////////////////////////////////////////////////////////////////////
	// Host write port
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			seq_q   <= fscs_pkg::RST_REG;
			win_q   <= fscs_pkg::RST_REG;
			dark_q  <= fscs_pkg::RST_REG;
			fill_q  <= fscs_pkg::RST_REG;
			gtime_q <= fscs_pkg::RST_REG;
			exp_q   <= fscs_pkg::RST_REG;
			gain_q  <= fscs_pkg::RST_REG;
			frz_q   <= fscs_pkg::RST_FREEZE;
			row_q   <= fscs_pkg::RST_REG;
			last_q  <= fscs_pkg::RST_REG;
			dec_q   <= fscs_pkg::RST_REG;
		end else if (cfg_wr) begin
			case (cfg_addr)
				fscs_pkg::ADDR_SEQ_CTRL:   seq_q   <= cfg_wdata;
				fscs_pkg::ADDR_WIN_SEL:    win_q   <= cfg_wdata;
				fscs_pkg::ADDR_DARK_ROWS:  dark_q  <= cfg_wdata;
				fscs_pkg::ADDR_FILL_ROWS:  fill_q  <= cfg_wdata;
				fscs_pkg::ADDR_GAIN_TIME:  gtime_q <= cfg_wdata;
				fscs_pkg::ADDR_EXPOSURE:   exp_q   <= cfg_wdata;
				fscs_pkg::ADDR_GAIN:       gain_q  <= cfg_wdata;
				fscs_pkg::ADDR_FREEZE:     frz_q   <= cfg_wdata;
				fscs_pkg::ADDR_ROW_ADDR:   row_q   <= cfg_wdata;
				fscs_pkg::ADDR_LAST_ROW:   last_q  <= cfg_wdata;
				fscs_pkg::ADDR_DECIMATION: dec_q   <= cfg_wdata;
				default: begin
				end
			endcase
		end
	end

	// Read port returns staged values, one cycle after the strobe
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= fscs_pkg::RST_REG;
		end else if (cfg_rd) begin
			case (cfg_addr)
				fscs_pkg::ADDR_SEQ_CTRL:   rdata_q <= seq_q;
				fscs_pkg::ADDR_WIN_SEL:    rdata_q <= win_q;
				fscs_pkg::ADDR_DARK_ROWS:  rdata_q <= dark_q;
				fscs_pkg::ADDR_FILL_ROWS:  rdata_q <= fill_q;
				fscs_pkg::ADDR_GAIN_TIME:  rdata_q <= gtime_q;
				fscs_pkg::ADDR_EXPOSURE:   rdata_q <= exp_q;
				fscs_pkg::ADDR_GAIN:       rdata_q <= gain_q;
				fscs_pkg::ADDR_FREEZE:     rdata_q <= frz_q;
				fscs_pkg::ADDR_ROW_ADDR:   rdata_q <= row_q;
				fscs_pkg::ADDR_LAST_ROW:   rdata_q <= last_q;
				fscs_pkg::ADDR_DECIMATION: rdata_q <= dec_q;
				default:                   rdata_q <= fscs_pkg::RST_REG;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Freeze bits and change detection
	assign sync_line  = frz_q[fscs_pkg::FRZ_HOLD_LINE_LENGTH];
	assign sync_dark  = frz_q[fscs_pkg::FRZ_DARK_ROWS];
	assign sync_fill  = frz_q[fscs_pkg::FRZ_FILL_ROWS];
	assign sync_exp   = frz_q[fscs_pkg::FRZ_EXPOSURE];
	assign sync_gain  = frz_q[fscs_pkg::FRZ_GAIN];
	assign sync_win   = frz_q[fscs_pkg::FRZ_WINDOW];
	assign gain_align = gtime_q[fscs_pkg::GAIN_ALIGN_BIT];

	assign dec_chg  = sync_win && (dec_q[fscs_pkg::DEC_W-1:0] != act_dec_q);
	assign rows_chg = (sync_dark && (dark_q != act_dark_q))
		|| (sync_fill && (fill_q != act_fill_q));
	// only a new window selection counts as a switch
	assign win_chg  = sync_win && seq_q[fscs_pkg::SEQ_BLANK_WIN_BIT]
		&& (win_q[fscs_pkg::WIN_MASK_W-1:0] != act_win_q);

	assign bif.frame_start = frame_start;
	// any settling change requests one blank frame
	assign bif.blank_req   = dec_chg || rows_chg || win_chg;

	fscs_blank_gen u_blank (
		.clock (clock),
		.rst_n (rst_n),
		.bif   (bif)
	);

	////////////////////////////////////////////////////////////////////////
	// line and row groups
	// one-edge group copy
	// Each group copies in one edge at frame start, never half-way
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			act_line_q <= fscs_pkg::RST_REG;
			act_dark_q <= fscs_pkg::RST_REG;
			act_fill_q <= fscs_pkg::RST_REG;
		end else if (frame_start) begin
			act_line_q <= fscs_pick(sync_line, line_length_in, act_line_q);
			act_dark_q <= fscs_pick(sync_dark, dark_q, act_dark_q);
			act_fill_q <= fscs_pick(sync_fill, fill_q, act_fill_q);
		end
	end

	// exposure group, no blank requested for it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			act_tick_q <= fscs_pkg::RST_REG;
			act_flen_q <= fscs_pkg::RST_REG;
			act_exp_q  <= fscs_pkg::RST_REG;
		end else if (frame_start && sync_exp) begin
			act_tick_q <= tick_scale_in;
			act_flen_q <= frame_length_cfg_in;
			act_exp_q  <= exp_q;
		end
	end

	// gain path with optional extra frame
	// gain freeze bit
	// The middle stage keeps gain one frame behind to match exposure latency
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			gain_mid_q <= fscs_pkg::RST_REG;
			act_gain_q <= fscs_pkg::RST_REG;
		end else if (frame_start) begin
			gain_mid_q <= fscs_pick(sync_gain, gain_q, gain_mid_q);
			if (gain_align) begin
				act_gain_q <= gain_mid_q;
			end else begin
				act_gain_q <= fscs_pick(sync_gain, gain_q, act_gain_q);
			end
		end
	end

	// window group; row address and last row sit inside it
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			act_win_q  <= fscs_pkg::RST_REG[fscs_pkg::WIN_MASK_W-1:0];
			act_dec_q  <= fscs_pkg::RST_REG[fscs_pkg::DEC_W-1:0];
			act_row_q  <= fscs_pkg::RST_REG;
			act_last_q <= fscs_pkg::RST_REG[fscs_pkg::LAST_ROW_W-1:0];
		end else if (frame_start && sync_win) begin
			act_win_q  <= win_q[fscs_pkg::WIN_MASK_W-1:0];
			act_dec_q  <= dec_q[fscs_pkg::DEC_W-1:0];
			act_row_q  <= row_q;
			act_last_q <= last_q[fscs_pkg::LAST_ROW_W-1:0];
		end
	end

	// blank flag registered so data and sync lanes switch together
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			blank_q <= 1'b0;
		end else begin
			blank_q <= bif.blank;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign cfg_rdata          = rdata_q;
	assign seq_ctrl           = seq_q;
	assign line_length        = act_line_q;
	assign frame_length_cfg   = act_flen_q;
	assign tick_scale         = act_tick_q;
	assign exposure           = act_exp_q;
	assign gain               = act_gain_q;
	assign dark_rows          = act_dark_q;
	assign filler_rows        = act_fill_q;
	assign window_enable_mask = act_win_q;
	assign decimation         = act_dec_q;
	assign row_address        = act_row_q;
	assign last_row           = act_last_q;
	// Blank shows one cycle after the state change; readout samples per frame
	assign blank_frame        = blank_q;
	assign training_pattern   = blank_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	// active values move only at frame start
	chk_hold_mid_frame: assert property (@(posedge clock) disable iff (!rst_n)
		!frame_start |=> $stable({act_exp_q, act_dark_q, act_dec_q, act_win_q}))
		else $error("active set changed inside a frame");

	// blank reaches both lanes for the frame
	chk_blank_train: assert property (@(posedge clock) disable iff (!rst_n)
		frame_start && bif.blank_req |=> ##1 blank_frame && training_pattern)
		else $error("blank request did not reach data and sync lanes");

	chk_dec_blank: assert property (@(posedge clock) disable iff (!rst_n)
		frame_start && sync_win && (dec_q[4:0] != act_dec_q)
		|=> (act_dec_q == $past(dec_q[4:0])) ##1 blank_frame)
		else $error("decimation change missed apply or blank");

	chk_rows_blank: assert property (@(posedge clock) disable iff (!rst_n)
		frame_start && sync_dark && (dark_q != act_dark_q) |=> ##1 blank_frame)
		else $error("dark row change did not blank");

	// window switch blanks only with the enable bit
	chk_win_blank: assert property (@(posedge clock) disable iff (!rst_n)
		frame_start && !seq_q[fscs_pkg::SEQ_BLANK_WIN_BIT] && !dec_chg && !rows_chg
		|=> ##1 !blank_frame)
		else $error("blank inserted without cause");

	// reselecting the same window never blanks
	chk_same_win: assert property (@(posedge clock) disable iff (!rst_n)
		frame_start && sync_win && (win_q[fscs_pkg::WIN_MASK_W-1:0] == act_win_q)
		&& !dec_chg && !rows_chg |=> ##1 !blank_frame)
		else $error("switch flagged without a new window");

	// exposure follows without blank when nothing else changes
	chk_exp_noblank: assert property (@(posedge clock) disable iff (!rst_n)
		frame_start && sync_exp && !bif.blank_req
		|=> (act_exp_q == $past(exp_q)) ##1 !blank_frame)
		else $error("exposure update blanked or was lost");

	chk_gain_direct: assert property (@(posedge clock) disable iff (!rst_n)
		frame_start && sync_gain && !gain_align |=> act_gain_q == $past(gain_q))
		else $error("gain not applied at frame start");

	// aligned gain takes the value staged one frame earlier
	chk_gain_align: assert property (@(posedge clock) disable iff (!rst_n)
		frame_start && gain_align |=> act_gain_q == $past(gain_mid_q))
		else $error("aligned gain skipped the extra frame");

	chk_freeze_hold: assert property (@(posedge clock) disable iff (!rst_n)
		frame_start && !sync_exp |=> $stable({act_tick_q, act_flen_q, act_exp_q}))
		else $error("frozen exposure group changed");

	chk_freeze_load: assert property (@(posedge clock) disable iff (!rst_n)
		frame_start && sync_fill |=> act_fill_q == $past(fill_q))
		else $error("filler rows not loaded after release");

	chk_gain_frozen: assert property (@(posedge clock) disable iff (!rst_n)
		frame_start && !sync_gain && !gain_align |=> $stable(act_gain_q))
		else $error("frozen gain changed");

	chk_win_group: assert property (@(posedge clock) disable iff (!rst_n)
		frame_start && !sync_win |=> $stable({act_win_q, act_dec_q, act_row_q, act_last_q}))
		else $error("frozen window group changed");

	// whole exposure group lands on the same edge
	chk_atomic_grp: assert property (@(posedge clock) disable iff (!rst_n)
		frame_start && sync_exp |=> {act_tick_q, act_flen_q, act_exp_q}
		== $past({tick_scale_in, frame_length_cfg_in, exp_q}))
		else $error("exposure group split across cycles");
endmodule : fscs_bank
`default_nettype wire

/* tb/fscs_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Register host: drives the configuration strobes as a serial bridge would
module fscs_host_model (
	input  wire logic        clock,
	output logic             cfg_wr,
	output logic             cfg_rd,
	output logic      [8:0]  cfg_addr,
	output logic      [15:0] cfg_wdata,
	input  wire logic [15:0] cfg_rdata
);
	// Idle strobes from time zero
	initial begin
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_addr = 9'h000;
		cfg_wdata = 16'h0000;
	end
	// One write; released lines show the inverse so stale data never looks valid
	task write_reg(input logic [8:0] a, input logic [15:0] d);
		@(posedge clock);
		cfg_wr <= 1'b1;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge clock);
		cfg_wr <= 1'b0;
		cfg_addr <= ~a;
		cfg_wdata <= ~d;
	endtask : write_reg
	// One read; data is taken once the accepting edge has landed
	task read_reg(input logic [8:0] a, output logic [15:0] d);
		@(posedge clock);
		cfg_rd <= 1'b1;
		cfg_addr <= a;
		@(posedge clock);
		cfg_rd <= 1'b0;
		cfg_addr <= ~a;
		#1 d = cfg_rdata;
	endtask : read_reg
endmodule : fscs_host_model
`default_nettype wire

/* tb/test_frame_synced_config_shadow.sv */
`timescale 1ns/100ps
`default_nettype none
module test_frame_synced_config_shadow;
	localparam int SQ = 0, WS = 1, DK = 2, FL = 3, GT = 4, EX = 5, GN = 6, FZ = 7;
	localparam int RA = 8, LR = 9, DC = 10;
	// Index 11 is an unmapped place
	localparam logic [8:0] AMAP [12] = '{fscs_pkg::ADDR_SEQ_CTRL, fscs_pkg::ADDR_WIN_SEL,
		fscs_pkg::ADDR_DARK_ROWS, fscs_pkg::ADDR_FILL_ROWS, fscs_pkg::ADDR_GAIN_TIME,
		fscs_pkg::ADDR_EXPOSURE, fscs_pkg::ADDR_GAIN, fscs_pkg::ADDR_FREEZE,
		fscs_pkg::ADDR_ROW_ADDR, fscs_pkg::ADDR_LAST_ROW, fscs_pkg::ADDR_DECIMATION, 9'h0d5};
	localparam int GRP [8] = '{DK, FL, EX, GN, WS, DC, RA, LR};
	logic        clock, rst_n, frame_start;
	logic [15:0] ll_in, fl_in, ts_in;
	wire         cfg_wr, cfg_rd, blank_frame, training_pattern;
	wire  [8:0]  cfg_addr;
	wire  [15:0] cfg_wdata, cfg_rdata, seq_ctrl, line_length, frame_length_cfg, tick_scale;
	wire  [15:0] exposure, gain, dark_rows, filler_rows, row_address;
	wire  [7:0]  window_enable_mask;
	wire  [4:0]  decimation;
	wire  [12:0] last_row;
	logic [15:0] st [12];
	logic [15:0] e_ll, e_fl, e_ts, e_ex, e_gn, e_dk, e_fr, e_ra, mid;
	logic [7:0]  e_mask;
	logic [4:0]  e_dec;
	logic [12:0] e_lr;
	int          bad_count, n_compared, cycles;

	fscs_bank DUT (.clock(clock), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
		.frame_start(frame_start), .line_length_in(ll_in), .frame_length_cfg_in(fl_in),
		.tick_scale_in(ts_in), .seq_ctrl(seq_ctrl), .line_length(line_length),
		.frame_length_cfg(frame_length_cfg), .tick_scale(tick_scale), .exposure(exposure),
		.gain(gain), .dark_rows(dark_rows), .filler_rows(filler_rows),
		.window_enable_mask(window_enable_mask), .decimation(decimation),
		.row_address(row_address), .last_row(last_row), .blank_frame(blank_frame),
		.training_pattern(training_pattern));
	fscs_host_model host (.clock(clock), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));

	// 100 MHz clock
	always #5 clock = ~clock;
	// Hang guard, well above the less than a thousand cycles the run needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////
	task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
		n_compared++;
		if (seen !== exp) begin
			bad_count++;
			$display("ERROR %0t: %s is %h, expected %h", $time, what, seen, exp);
		end
	endtask : check
	task final_report();
		$display("Compared %0d, mismatches %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : final_report
	// Staged copy follows every accepted write; the unmapped place keeps nothing
	task wr(input int i, input logic [15:0] d);
		host.write_reg(AMAP[i], d);
		if (i < 11) st[i] = d;
	endtask : wr
	task rd_chk(input int i);
		logic [15:0] d;
		host.read_reg(AMAP[i], d);
		check(d, (i < 11) ? st[i] : 16'h0000, "readback");
	endtask : rd_chk
	task chk_blank(input logic exp);
		check({15'h0000, blank_frame}, {15'h0000, exp}, "blank");
		check({15'h0000, training_pattern}, {15'h0000, exp}, "training");
	endtask : chk_blank
	task check_all();
		check(line_length, e_ll, "line length");
		check(frame_length_cfg, e_fl, "frame length");
		check(tick_scale, e_ts, "tick scale");
		check(exposure, e_ex, "exposure");
		check(gain, e_gn, "gain");
		check(dark_rows, e_dk, "dark rows");
		check(filler_rows, e_fr, "filler rows");
		check({8'h00, window_enable_mask}, {8'h00, e_mask}, "mask");
		check({11'h000, decimation}, {11'h000, e_dec}, "decimation");
		check(row_address, e_ra, "row address");
		check({3'h0, last_row}, {3'h0, e_lr}, "last row");
		check(seq_ctrl, st[SQ], "sequencer control");
	endtask : check_all
	// One frame boundary; the expected active set is worked out from the staged copy
	task frame();
		logic req;
		@(posedge clock);
		frame_start <= 1'b1;
		ll_in <= 16'($urandom);
		fl_in <= 16'($urandom);
		ts_in <= 16'($urandom);
		@(posedge clock);
		frame_start <= 1'b0;
		req = 1'b0;
		if (st[FZ][0]) e_ll = ll_in;
		if (st[FZ][1]) begin
			req = req | (st[DK] != e_dk);
			e_dk = st[DK];
		end
		if (st[FZ][2]) begin
			req = req | (st[FL] != e_fr);
			e_fr = st[FL];
		end
		if (st[FZ][3]) begin
			e_fl = fl_in;
			e_ts = ts_in;
			e_ex = st[EX];
		end
		if (st[GT][13]) e_gn = mid;
		else if (st[FZ][4]) e_gn = st[GN];
		// Middle gain stage follows the gain freeze bit like the active copy
		if (st[FZ][4]) mid = st[GN];
		if (st[FZ][5]) begin
			req = req | ((st[WS][7:0] != e_mask) && st[SQ][9]);
			req = req | (st[DC][4:0] != e_dec);
			e_mask = st[WS][7:0];
			e_dec = st[DC][4:0];
			e_ra = st[RA];
			e_lr = st[LR][12:0];
		end
		#1 check_all();
		repeat (2) @(posedge clock);
		#1 chk_blank(req);
	endtask : frame
	////////////////////////////////////////////////////////////////
	initial begin
		int i, k;
		clock = 1'b0;
		rst_n = 1'b0;
		frame_start = 1'b0;
		{ll_in, fl_in, ts_in} = '0;
		{bad_count, n_compared, cycles} = '0;
		foreach (st[j]) st[j] = fscs_pkg::RST_REG;
		st[FZ] = fscs_pkg::RST_FREEZE;
		{e_ll, e_fl, e_ts, e_ex, e_gn, e_dk, e_fr, e_ra, mid, e_mask, e_dec, e_lr} = '0;
		k = $urandom(28);
		repeat (10) @(posedge clock);
		rst_n <= 1'b1;
		#1 check_all();
		chk_blank(1'b0);
		for (i = 0; i < 12; i++) rd_chk(i);
		// Staged exposure must not touch the running frame
		wr(EX, 16'h1234);
		#1 check(exposure, 16'h0000, "early exposure");
		frame();
		// Decimation change with matching row fields, then a quiet frame
		wr(DC, 16'h0003);
		wr(RA, 16'h0061);
		wr(LR, 16'h09c3);
		frame();
		frame();
		wr(DK, 16'h0010);
		frame();
		wr(FL, 16'h0004);
		frame();
		// Window switch without and with blanking, then the same window again
		wr(WS, 16'h0005);
		frame();
		wr(SQ, 16'h0200);
		wr(WS, 16'h0006);
		frame();
		wr(WS, 16'h0006);
		frame();
		// Gain plain, then aligned one frame later
		wr(GN, 16'h00aa);
		frame();
		wr(GT, 16'h2000);
		frame();
		frame();
		wr(GN, 16'h0055);
		frame();
		frame();
		wr(GT, 16'h0000);
		frame();
		frame();
		// Each group frozen across a two-frame upload, then released
		for (i = 0; i < 6; i++) begin
			wr(FZ, 16'h003f & ~(16'h0001 << i));
			foreach (GRP[j]) wr(GRP[j], 16'($urandom));
			frame();
			frame();
			wr(FZ, 16'h003f);
			frame();
		end
		// Random traffic, unmapped place included; alignment stays off here
		for (i = 0; i < 40; i++) begin
			repeat ($urandom_range(0, 3)) begin
				k = $urandom_range(0, 11);
				wr(k, (k == GT) ? 16'($urandom) & 16'hdfff : 16'($urandom));
			end
			rd_chk($urandom_range(0, 11));
			frame();
		end
		final_report();
	end
endmodule : test_frame_synced_config_shadow
`default_nettype wire
